// file: testbench/mipfm_host.sv
// host spi controller model
`timescale 1ns/1ns
module mipfm_host (
	// core clock for pacing
	input wire logic clk_i,
	// spi pins toward device
	output logic sck_o,
	output logic cs_n_o,
	output logic [3:0] d_o,
	output logic [3:0] en_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		d_o = 4'hF;
		en_o = 4'hF;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wt
	// lanes, enables and select, held steady until changed
	task automatic drv(input logic [3:0] d, e, input logic c);
		d_o = d;
		en_o = e;
		cs_n_o = c;
	endtask : drv
	// one sck period of 8 core cycles, idle low outside
	task automatic clk1(input logic [3:0] d);
		d_o = d;
		wt(4);
		sck_o = 1'b1;
		wt(4);
		sck_o = 1'b0;
	endtask : clk1
endmodule : mipfm_host

// file: testbench/mipfm_top_chk.sv
// assertions for the pin function mux
`timescale 1ns/1ns
module mipfm_top_chk (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic HW_RESET_N_I,
	input wire logic READ_PHASE_I,
	input wire mipfm_pkg::mipfm_cfg_t CFG_I,
	input wire mipfm_pkg::mipfm_width_t WIDTH_I,
	input wire mipfm_pkg::mipfm_lanes_out_t LANE_O,
	input wire logic WRITE_PROTECT_ACTIVE_O,
	input wire logic LANE3_IS_DATA_O,
	input wire logic LANE3_IS_RESET_O,
	input wire logic DEVICE_RESET_O,
	input wire logic STANDBY_O
);
	import mipfm_pkg::*;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	AST_HWRST: assert property (!HW_RESET_N_I[*4] |-> ##[0:2] DEVICE_RESET_O)
		else $error("no reset");
	AST_RSTQ: assert property (DEVICE_RESET_O |-> !STANDBY_O && !LANE_O.oe)
		else $error("reset not quiet");
	AST_L0: assert property (WIDTH_I == MIPFM_SINGLE && $stable(WIDTH_I) |-> !LANE_O.oe[0])
		else $error("lane0 driven");
	AST_NORD: assert property (!READ_PHASE_I[*6] |-> LANE_O.oe[2:0] == 3'h0)
		else $error("lanes driven");
	AST_WP: assert property (WRITE_PROTECT_ACTIVE_O |-> CFG_I.status_protect_bit && !CFG_I.quad_enable_bit)
		else $error("bad protect");
	AST_L2: assert property (!CFG_I.quad_enable_bit && $stable(CFG_I) |-> !LANE_O.oe[2])
		else $error("lane2 driven");
	AST_L3D: assert property (LANE3_IS_DATA_O |-> CFG_I.quad_enable_bit || CFG_I.four_wire_cmd_enable_bit)
		else $error("lane3 data");
	AST_L3R: assert property (LANE3_IS_RESET_O |-> CFG_I.lane3_reset_enable_bit && !LANE3_IS_DATA_O)
		else $error("lane3 reset");
endmodule : mipfm_top_chk
bind mipfm_top mipfm_top_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
	.HW_RESET_N_I(HW_RESET_N_I), .READ_PHASE_I(READ_PHASE_I), .CFG_I(CFG_I),
	.WIDTH_I(WIDTH_I), .LANE_O(LANE_O), .STANDBY_O(STANDBY_O),
	.WRITE_PROTECT_ACTIVE_O(WRITE_PROTECT_ACTIVE_O), .LANE3_IS_DATA_O(LANE3_IS_DATA_O),
	.LANE3_IS_RESET_O(LANE3_IS_RESET_O), .DEVICE_RESET_O(DEVICE_RESET_O));

// file: testbench/tb.sv
// self-checking bench for the pin function mux
`timescale 1ns/1ns
module tb;
	import mipfm_pkg::*;
	logic clk, rst_n, hw_n, rdp, rxv, txs, wpa, l3d, l3r, drst, stby, sck, cs_n;
	logic [3:0] txd, rxd, lane, hd, hen, rxq;
	mipfm_cfg_t cfg;
	mipfm_width_t wid;
	mipfm_lanes_out_t lo;
	int mismatches = 0, compares = 0, cyc = 0, txn = 0;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always_comb for (int i = 0; i < 4; i++)
		lane[i] = lo.oe[i] ? lo.o[i] : hen[i] ? hd[i] : (i > 1 ? 1'b1 : ~hd[i]);
	mipfm_host h (.clk_i(clk), .sck_o(sck), .cs_n_o(cs_n), .d_o(hd), .en_o(hen));
	mipfm_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .SCK_I(sck), .CS_N_I(cs_n),
		.HW_RESET_N_I(hw_n), .LANE_I(lane), .LANE_O(lo), .CFG_I(cfg), .WIDTH_I(wid),
		.READ_PHASE_I(rdp), .TX_DATA_I(txd), .RX_DATA_O(rxd), .RX_VALID_O(rxv),
		.TX_SHIFT_O(txs), .WRITE_PROTECT_ACTIVE_O(wpa), .LANE3_IS_DATA_O(l3d),
		.LANE3_IS_RESET_O(l3r), .DEVICE_RESET_O(drst), .STANDBY_O(stby));
	task automatic conclude;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rxv)
			rxq <= rxd;
		if (txs)
			txn <= txn + 1;
		if (cyc == 20000) begin
			mismatches++;
			conclude;
		end
	end
	task automatic chk(input string n, input logic [3:0] e, g);
		compares++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", n, e, g);
			mismatches++;
		end
	endtask : chk
	task automatic t_rst;
		chk("stby", 4'h1, {3'h0, stby});
		hw_n = 1'b0;
		h.wt(10);
		chk("drst", 4'h1, {3'h0, drst});
		hw_n = 1'b1;
		h.wt(12);
		chk("stby2", 4'h1, {3'h0, stby});
	endtask : t_rst
	task automatic t_io;
		h.drv(4'hF, 4'hF, 1'b0);
		h.wt(4);
		h.clk1(4'h1);
		h.wt(4);
		chk("rx0", 4'h1, rxq);
		rdp = 1'b1;
		txd = 4'h1;
		h.drv(4'h0, 4'h1, 1'b0);
		h.clk1(4'h0);
		h.wt(4);
		chk("oe1", 4'h2, lo.oe);
		chk("o1", 4'h2, lo.o & 4'h2);
		cfg = '{1'b1, 1'b0, 1'b1, 1'b0};
		wid = MIPFM_QUAD;
		txd = 4'hA;
		h.drv(4'h0, 4'h0, 1'b0);
		h.clk1(4'h0);
		h.wt(4);
		chk("oeq", 4'hF, lo.oe);
		chk("oq", 4'hA, lo.o);
		chk("l3", 4'h2, {2'h0, l3d, l3r});
		rdp = 1'b0;
		h.drv(4'h0, 4'h7, 1'b1);
		h.wt(6);
		chk("l3hi", 4'h8, lo.oe & lo.o & 4'h8);
	endtask : t_io
	task automatic t_l3;
		cfg = '{1'b0, 1'b0, 1'b1, 1'b1};
		wid = MIPFM_SINGLE;
		h.drv(4'hB, 4'hF, 1'b0);
		h.wt(6);
		chk("wp", 4'h1, {3'h0, wpa});
		chk("l3r", 4'h1, {3'h0, l3r});
		h.drv(4'h7, 4'hF, 1'b1);
		h.wt(3);
		h.drv(4'hF, 4'hF, 1'b1);
		h.wt(8);
		chk("short", 4'h0, {3'h0, drst});
		h.drv(4'h7, 4'hF, 1'b1);
		h.wt(12);
		chk("long", 4'h1, {3'h0, drst});
		h.drv(4'hF, 4'hF, 1'b1);
		h.wt(12);
	endtask : t_l3
	task automatic t_wide;
		cfg = '{1'b0, 1'b1, 1'b0, 1'b0};
		wid = MIPFM_QUAD;
		txd = 4'hD;
		rdp = 1'b1;
		h.drv(4'h0, 4'h0, 1'b0);
		h.clk1(4'h0);
		h.wt(4);
		chk("rxqpi", 4'hF, rxq);
		chk("oeqpi", 4'hB, lo.oe);
		chk("oqpi", 4'hD, lo.o);
		chk("l3qpi", 4'h2, {2'h0, l3d, l3r});
		wid = MIPFM_DUAL;
		txd = 4'h6;
		h.clk1(4'h0);
		h.wt(4);
		chk("oedual", 4'h3, lo.oe);
		chk("odual", 4'h2, lo.o & 4'h3);
		chk("txs", 4'h4, 4'(txn));
		rdp = 1'b0;
		h.drv(4'hF, 4'hF, 1'b1);
		h.wt(6);
	endtask : t_wide
	initial begin
		rst_n = 1'b0;
		hw_n = 1'b1;
		rdp = 1'b0;
		txd = 4'h0;
		cfg = '0;
		wid = MIPFM_SINGLE;
		h.wt(4);
		rst_n = 1'b1;
		h.wt(12);
		t_rst;
		t_io;
		t_l3;
		t_wide;
		conclude;
	end
endmodule : tb

// file: verilog/mipfm_pkg.sv
// types for the multi-I/O pin function mux
package mipfm_pkg;
	typedef enum logic [1:0] {MIPFM_SINGLE, MIPFM_DUAL, MIPFM_QUAD}
		mipfm_width_t;
	typedef struct packed {
		logic quad_enable_bit;
		logic four_wire_cmd_enable_bit;
		logic lane3_reset_enable_bit;
		logic status_protect_bit;
	} mipfm_cfg_t;
	typedef struct packed {
		logic [3:0] o;
		logic [3:0] oe;
	} mipfm_lanes_out_t;
	typedef enum {MIPFM_ST_RESET, MIPFM_ST_STANDBY, MIPFM_ST_ACTIVE}
		mipfm_state_t;
endpackage : mipfm_pkg

// file: verilog/mipfm_regs.svh
// constants for the multi-I/O pin function mux
`ifndef MIPFM_REGS_SVH
`define MIPFM_REGS_SVH
// reset pulse least time in ns
`define MIPFM_RESET_PULSE_NS 200
`define MIPFM_CLK_PERIOD_NS 40
`define MIPFM_RESET_PULSE_CYC \
	((`MIPFM_RESET_PULSE_NS + `MIPFM_CLK_PERIOD_NS - 1) / `MIPFM_CLK_PERIOD_NS)
`define MIPFM_CNT_W 8
// standby release delay after reset, cycles
`define MIPFM_RESET_HOLD_CYC 8'h04
`endif

// file: verilog/mipfm_sync.sv
// two-flop synchroniser bank with sync outputs
`timescale 1ns/1ns
module mipfm_sync (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// async inputs and synchronised copies
	input wire logic [6:0] async_i,
	output logic [6:0] sync_o
);
	logic [6:0] meta_r;
	logic [6:0] sync_r;
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			// sck idles low, the rest idle high
			meta_r <= 7'h3F;
			sync_r <= 7'h3F;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end
	assign sync_o = sync_r;
endmodule : mipfm_sync

// file: verilog/mipfm_top.sv
// pin function mux for a multi-I/O serial memory interface
`timescale 1ns/1ns
`include "mipfm_regs.svh"
module mipfm_top (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// spi pins
	input wire logic SCK_I,
	input wire logic CS_N_I,
	input wire logic HW_RESET_N_I,
	input wire logic [3:0] LANE_I,
	output mipfm_pkg::mipfm_lanes_out_t LANE_O,
	// configuration bits
	input wire mipfm_pkg::mipfm_cfg_t CFG_I,
	// command width from decoder
	input wire mipfm_pkg::mipfm_width_t WIDTH_I,
	input wire logic READ_PHASE_I,
	input wire logic [3:0] TX_DATA_I,
	// status toward core
	output logic [3:0] RX_DATA_O,
	output logic RX_VALID_O,
	output logic TX_SHIFT_O,
	output logic WRITE_PROTECT_ACTIVE_O,
	output logic LANE3_IS_DATA_O,
	output logic LANE3_IS_RESET_O,
	output logic DEVICE_RESET_O,
	output logic STANDBY_O
);
	import mipfm_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic sck_d;
		mipfm_state_t st;
		logic [`MIPFM_CNT_W-1:0] rst_cnt;
		logic [`MIPFM_CNT_W-1:0] hold_cnt;
		logic read_done;
		logic [3:0] rx;
		logic rx_v;
		logic tx_sh;
		mipfm_lanes_out_t lo;
	} mipfm_top_state_t;

	mipfm_top_state_t s_r;
	mipfm_top_state_t s_nxt;
	logic [6:0] sync_w;
	logic sck_s;
	logic cs_n_s;
	logic hw_rst_n_s;
	logic [3:0] lane_s;
	logic sck_rise;
	logic sck_fall;
	logic quad_on;
	logic l3_data;
	logic l3_reset;
	logic wp_active;
	logic reset_hit;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	mipfm_sync u_sync (
		.CORE_CLK_I(CORE_CLK_I),
		.RST_N_I(RST_N_I),
		.async_i({SCK_I, CS_N_I, HW_RESET_N_I, LANE_I}),
		.sync_o(sync_w)
	);
	assign sck_s = sync_w[6];
	assign cs_n_s = sync_w[5];
	assign hw_rst_n_s = sync_w[4];
	assign lane_s = sync_w[3:0];
	assign sck_rise = sck_s && !s_r.sck_d;
	assign sck_fall = !sck_s && s_r.sck_d;

	// ------------------------------------------------------------
	// pin function decode
	// ------------------------------------------------------------
	assign quad_on = CFG_I.quad_enable_bit || CFG_I.four_wire_cmd_enable_bit;
	assign wp_active = !CFG_I.quad_enable_bit &&
		CFG_I.status_protect_bit;
	assign l3_data = !cs_n_s && quad_on;
	assign l3_reset = CFG_I.lane3_reset_enable_bit &&
		(!quad_on || cs_n_s);
	assign reset_hit = l3_reset && cs_n_s && !lane_s[3] &&
		(s_r.rst_cnt >= `MIPFM_CNT_W'(`MIPFM_RESET_PULSE_CYC - 1));

	function automatic logic lane_drives(input mipfm_width_t w,
		input logic [1:0] idx, input logic q);
		case (w)
			MIPFM_SINGLE: lane_drives = (idx == 2'h1);
			MIPFM_DUAL: lane_drives = (idx <= 2'h1);
			MIPFM_QUAD: lane_drives = q;
			default: lane_drives = 1'b0;
		endcase
	endfunction : lane_drives

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.sck_d = sck_s;
		s_nxt.rx_v = 1'b0;
		s_nxt.tx_sh = 1'b0;
		if (l3_reset && cs_n_s && !lane_s[3]) begin
			// saturate so a long low pulse keeps the reset
			if (s_r.rst_cnt != '1) begin
				s_nxt.rst_cnt = s_r.rst_cnt + `MIPFM_CNT_W'(1);
			end
		end else begin
			s_nxt.rst_cnt = '0;
		end
		case (s_r.st)
			MIPFM_ST_RESET: begin
				s_nxt.lo = '0;
				s_nxt.read_done = 1'b0;
				if (hw_rst_n_s && !reset_hit) begin
					if (s_r.hold_cnt == '0) begin
						s_nxt.st = MIPFM_ST_STANDBY;
					end else begin
						s_nxt.hold_cnt = s_r.hold_cnt - `MIPFM_CNT_W'(1);
					end
				end else begin
					s_nxt.hold_cnt = `MIPFM_RESET_HOLD_CYC;
				end
			end
			MIPFM_ST_STANDBY: begin
				s_nxt.lo.oe = 4'h0;
				if (s_r.read_done && cs_n_s && quad_on) begin
					s_nxt.lo.o[3] = 1'b1;
					s_nxt.lo.oe[3] = 1'b1;
				end
				if (!cs_n_s) begin
					s_nxt.st = MIPFM_ST_ACTIVE;
					s_nxt.read_done = 1'b0;
				end
			end
			MIPFM_ST_ACTIVE: begin
				if (sck_rise) begin
					s_nxt.rx = lane_s;
					s_nxt.rx_v = 1'b1;
				end
				if (READ_PHASE_I && sck_fall) begin
					s_nxt.tx_sh = 1'b1;
					for (int i = 0; i < 4; i++) begin
						s_nxt.lo.oe[i] = lane_drives(WIDTH_I, 2'(i),
							(i < 2) ? 1'b1 : (i == 2) ?
							CFG_I.quad_enable_bit : l3_data);
					end
					s_nxt.lo.o = (WIDTH_I == MIPFM_SINGLE) ?
						{2'h0, TX_DATA_I[0], 1'b0} : TX_DATA_I;
					s_nxt.read_done = 1'b1;
				end else if (!READ_PHASE_I) begin
					s_nxt.lo.oe = 4'h0;
				end
				if (cs_n_s) begin
					s_nxt.st = MIPFM_ST_STANDBY;
					s_nxt.lo.oe = 4'h0;
				end
			end
			default: s_nxt.st = MIPFM_ST_RESET;
		endcase
		if (!hw_rst_n_s || reset_hit) begin
			s_nxt.st = MIPFM_ST_RESET;
			s_nxt.lo = '0;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s_r <= '{sck_d: 1'b0, st: MIPFM_ST_RESET,
				rst_cnt: '0, hold_cnt: `MIPFM_RESET_HOLD_CYC,
				read_done: 1'b0, rx: 4'h0, rx_v: 1'b0, tx_sh: 1'b0,
				lo: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign LANE_O = s_r.lo;
	assign RX_DATA_O = s_r.rx;
	assign RX_VALID_O = s_r.rx_v;
	assign TX_SHIFT_O = s_r.tx_sh;
	assign WRITE_PROTECT_ACTIVE_O = wp_active && !lane_s[2];
	assign LANE3_IS_DATA_O = l3_data;
	assign LANE3_IS_RESET_O = l3_reset;
	assign DEVICE_RESET_O = (s_r.st == MIPFM_ST_RESET);
	assign STANDBY_O = (s_r.st == MIPFM_ST_STANDBY);
endmodule : mipfm_top
